/* design/asq_pkg.sv */
// Constants, register map and state types for the scan-mode sequencer.
// Assumes a 10 MHz bus clock and word-aligned AHB-Lite register access.
package asq_pkg;

    // ========================================
    // Clock and pacing
    localparam int CLK_PERIOD_NS = 100;
    localparam int INT_PACE_NS   = 2000;
    localparam int INT_PACE_CYC  = (INT_PACE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PACE_W        = 8;

    // ========================================
    // Register byte offsets
    localparam logic [7:0] OFS_MODE    = 8'h00;
    localparam logic [7:0] OFS_LIST_LO = 8'h04;
    localparam logic [7:0] OFS_LIST_HI = 8'h08;
    localparam logic [7:0] OFS_CFG     = 8'h0C;
    localparam logic [7:0] OFS_CMD     = 8'h10;
    localparam logic [7:0] OFS_STATUS  = 8'h14;
    localparam logic [7:0] OFS_RESULT  = 8'h18;

    // ========================================
    // Field positions
    localparam int MODE_SCAN_LSB  = 11;
    localparam int MODE_CHSEL_LSB = 7;
    localparam int ST_CH_LSB      = 4;
    localparam int ST_CNT_LSB     = 8;
    localparam int ST_MODE_LSB    = 16;
    localparam int RES_VALID_BIT  = 16;

    // ========================================
    // Scan codes handled here
    localparam logic [3:0] SCAN_STD_EXT = 4'h4;
    localparam logic [3:0] SCAN_UP_INT  = 4'h5;
    localparam logic [3:0] SCAN_UP_EXT  = 4'h6;
    localparam logic [3:0] SCAN_CUS_INT = 4'h7;
    localparam logic [3:0] SCAN_CUS_EXT = 4'h8;

    // ========================================
    // Variant channel count codes and reset values
    localparam logic [1:0] VAR_4CH   = 2'h0;
    localparam logic [1:0] VAR_8CH   = 2'h1;
    localparam logic [3:0] HI_4CH    = 4'h3;
    localparam logic [3:0] HI_8CH    = 4'h7;
    localparam logic [3:0] HI_16CH   = 4'hF;
    localparam logic [1:0] RST_VAR   = 2'h2;
    localparam logic [3:0] RST_MODE  = SCAN_STD_EXT;
    localparam logic [4:0] MAX_CONV  = 5'h10;
    localparam int         NCH       = 16;
    localparam int         RES_W     = 16;
    localparam int         DATA_W    = 12;

    typedef enum logic [1:0] {ST_IDLE, ST_ISSUE, ST_WAIT, ST_HAND} asq_state_t;

endpackage

/* design/asq_stream_if.sv */
// Valid/ready word stream between the sequencer and its output buffer.
// Assumes both ends run on the one bus clock.
`timescale 1ns/1ps
interface asq_stream_if;
    import asq_pkg::*;
    logic             valid;
    logic             ready;
    logic [RES_W-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

/* design/asq_pair_buf.sv */
// Two-entry buffer: head and spare register, all outputs from flops.
// Assumes a single clock and asynchronous active-low reset.
`timescale 1ns/1ps
module asq_pair_buf
    import asq_pkg::*;
(
    input  wire logic   hclk,
    input  wire logic   hresetn,
    asq_stream_if.snk   in_s,
    asq_stream_if.src   out_s
);
    logic             head_v_reg;
    logic             spare_v_reg;
    logic [RES_W-1:0] head_reg;
    logic [RES_W-1:0] spare_reg;
    logic             pop;
    logic             push;

    // Handshakes on both sides
    assign pop          = head_v_reg & out_s.ready;
    assign push         = in_s.valid & ~spare_v_reg;
    assign in_s.ready   = ~spare_v_reg;
    assign out_s.valid  = head_v_reg;
    assign out_s.data   = head_reg;

    // ========================================
    // Storage update
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            head_v_reg  <= 1'b0;
            spare_v_reg <= 1'b0;
            head_reg    <= '0;
            spare_reg   <= '0;
        end else if (pop) begin
            if (spare_v_reg) begin
                head_reg    <= spare_reg;   // Spare moves up
                spare_v_reg <= 1'b0;
            end else if (push) begin
                head_reg    <= in_s.data;
            end else begin
                head_v_reg  <= 1'b0;
            end
        end else if (push) begin
            if (head_v_reg) begin
                spare_reg   <= in_s.data;   // Receiver stalled
                spare_v_reg <= 1'b1;
            end else begin
                head_reg    <= in_s.data;
                head_v_reg  <= 1'b1;
            end
        end
    end

    // ========================================
    // Checks
    a_no_overfill: assert property (@(posedge hclk) disable iff (!hresetn)
        spare_v_reg |-> head_v_reg) else $error("spare filled while head empty");
    a_stall_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        (head_v_reg && !out_s.ready) |=> (head_v_reg && $stable(head_reg)))
        else $error("head changed under stall");
    c_buf_full: cover property (@(posedge hclk) disable iff (!hresetn) spare_v_reg);
endmodule

/* design/asq_top.sv */
// Scan-mode sequencer with AHB-Lite registers, result FIFO and stream out.
// Assumes a converter that answers each conv_start with one conv_done pulse,
// and a link that gives one ext_tick per serial frame.
//
// The implementer's own choices: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps
module asq_top
    import asq_pkg::*;
(
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic              hsel,
    input  wire logic [7:0]        haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic                   hreadyout,
    output logic                   hresp,
    output logic [31:0]            hrdata,
    input  wire logic              ext_tick,
    input  wire logic              conv_done,
    input  wire logic [DATA_W-1:0] conv_data,
    output logic                   conv_start,
    output logic [3:0]             conv_channel,
    output logic                   conv_avg,
    output logic                   res_valid,
    output logic [RES_W-1:0]       res_data,
    input  wire logic              res_ready
);
    // ========================================
    // Declarations
    asq_state_t       state_reg;
    logic [3:0]       mode_reg;
    logic [3:0]       channel_pick_field;
    logic [7:0]       channel_list_low_reg;
    logic [7:0]       channel_list_high_reg;
    logic [1:0]       var_reg;
    logic [3:0]       run_mode_reg;
    logic [3:0]       run_pick_reg;
    logic [3:0]       ch_reg;
    logic [4:0]       cnt_reg;
    logic             first_reg;
    logic [RES_W-1:0] res_reg;
    logic [PACE_W-1:0] pace_reg;
    logic             int_tick;
    logic             wr_pend_reg;
    logic [7:0]       wr_addr_reg;
    logic [RES_W-1:0] fifo_mem [NCH];
    logic [3:0]       fifo_wp_reg;
    logic [3:0]       fifo_rp_reg;
    logic [4:0]       fifo_cnt_reg;
    logic             fifo_push;
    logic             fifo_pop;
    logic             addr_ok;
    logic             start_req;
    logic             run_int;
    logic             run_custom;
    logic             run_std;
    logic [3:0]       hi_chan;
    logic [NCH-1:0]   chan_en;
    logic [NCH-1:0]   list_all;
    logic [4:0]       from_ch;
    logic             nxt_found;
    logic [3:0]       nxt_ch;
    logic             pace_ok;
    logic [3:0]       wr_scan;
    asq_stream_if     buf_in ();
    asq_stream_if     buf_out ();

    // ========================================
    // Mode decode of the running sequence
    assign run_int    = (run_mode_reg == SCAN_UP_INT) || (run_mode_reg == SCAN_CUS_INT);
    assign run_custom = (run_mode_reg == SCAN_CUS_INT) || (run_mode_reg == SCAN_CUS_EXT);
    assign run_std    = (run_mode_reg == SCAN_STD_EXT);
    assign hi_chan    = (var_reg == VAR_4CH) ? HI_4CH : (var_reg == VAR_8CH) ? HI_8CH : HI_16CH;
    assign list_all   = {channel_list_high_reg, channel_list_low_reg};

    // Per-channel enable: list in custom modes, range up to N in standard mode, from N in upper modes
    for (genvar i = 0; i < NCH; i++) begin : g_chan
        localparam logic [3:0] IDX = 4'(i);
        assign chan_en[i] = (IDX <= hi_chan) &&
            (run_custom ? list_all[i]
                        : (run_std ? (IDX <= run_pick_reg)
                                   : (IDX >= run_pick_reg)));
    end

    // Lowest enabled channel above the last one keeps the order ascending
    assign from_ch = first_reg ? 5'h00 : ({1'b0, ch_reg} + 5'h01);
    always_comb begin
        nxt_found = 1'b0;
        nxt_ch    = 4'h0;
        for (int i = NCH - 1; i >= 0; i--) begin
            if (chan_en[i] && (5'(i) >= from_ch)) begin
                nxt_found = 1'b1;
                nxt_ch    = 4'(i);
            end
        end
    end

    // Pace source: internal divider or serial frame tick
    assign pace_ok = run_int ? (int_tick && (fifo_cnt_reg < MAX_CONV)) : ext_tick;

    // ========================================
    // Internal conversion pacing divider
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pace_reg <= '0;
            int_tick <= 1'b0;
        end else if (pace_reg == PACE_W'(INT_PACE_CYC - 1)) begin
            pace_reg <= '0;
            int_tick <= 1'b1;
        end else begin
            pace_reg <= pace_reg + PACE_W'(1);
            int_tick <= 1'b0;
        end
    end

    // ========================================
    // AHB-Lite address phase capture and read data
    assign addr_ok   = hsel && htrans[1] && hready;
    assign fifo_pop  = addr_ok && !hwrite && (haddr == OFS_RESULT) && (fifo_cnt_reg != 5'h00);
    assign start_req = wr_pend_reg && (wr_addr_reg == OFS_CMD) && hwdata[0];
    assign wr_scan   = hwdata[MODE_SCAN_LSB +: 4];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= '0;
            hrdata      <= '0;
            hreadyout   <= 1'b1;
            hresp       <= 1'b0;
        end else begin
            wr_pend_reg <= addr_ok && hwrite;
            if (addr_ok) wr_addr_reg <= haddr;
            hrdata <= '0;
            if (addr_ok && !hwrite) begin
                case (haddr)
                    OFS_MODE:    hrdata <= 32'(mode_reg) << MODE_SCAN_LSB | 32'(channel_pick_field) << MODE_CHSEL_LSB;
                    OFS_LIST_LO: hrdata <= 32'(channel_list_low_reg);
                    OFS_LIST_HI: hrdata <= 32'(channel_list_high_reg);
                    OFS_CFG:     hrdata <= 32'(var_reg);
                    OFS_STATUS:  hrdata <= 32'(state_reg != ST_IDLE) | 32'(ch_reg) << ST_CH_LSB |
                                           32'(fifo_cnt_reg) << ST_CNT_LSB | 32'(run_mode_reg) << ST_MODE_LSB;
                    OFS_RESULT:  hrdata <= (fifo_cnt_reg != 5'h00) ?
                                           (32'(fifo_mem[fifo_rp_reg]) | 32'h0001_0000) : 32'h0000_0000;
                    default:     hrdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ========================================
    // Register writes in the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_reg              <= RST_MODE;
            channel_pick_field    <= 4'h0;
            channel_list_low_reg  <= 8'h00;
            channel_list_high_reg <= 8'h00;
            var_reg               <= RST_VAR;
        end else if (wr_pend_reg) begin
            case (wr_addr_reg)
                OFS_MODE: begin
                    // Unused codes leave mode and pick field alone
                    if (wr_scan >= SCAN_STD_EXT && wr_scan <= SCAN_CUS_EXT) begin
                        mode_reg           <= wr_scan;
                        channel_pick_field <= hwdata[MODE_CHSEL_LSB +: 4];
                    end
                end
                OFS_LIST_LO: channel_list_low_reg  <= hwdata[7:0];
                OFS_LIST_HI: channel_list_high_reg <= hwdata[7:0];
                OFS_CFG:     var_reg               <= hwdata[1:0];
                default: ;
            endcase
        end
    end

    // ========================================
    // Sequencer state machine
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg    <= ST_IDLE;
            run_mode_reg <= RST_MODE;
            run_pick_reg <= 4'h0;
            ch_reg       <= 4'h0;
            cnt_reg      <= 5'h00;
            first_reg    <= 1'b1;
            res_reg      <= '0;
            conv_start   <= 1'b0;
            conv_channel <= 4'h0;
            conv_avg     <= 1'b0;
        end else begin
            conv_start <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    if (start_req) begin
                        run_mode_reg <= mode_reg;
                        run_pick_reg <= channel_pick_field;
                        first_reg    <= 1'b1;
                        cnt_reg      <= 5'h00;
                        state_reg    <= ST_ISSUE;
                    end
                end
                ST_ISSUE: begin
                    if (!nxt_found || cnt_reg == MAX_CONV) begin
                        state_reg <= ST_IDLE;
                    end else if (pace_ok) begin
                        conv_start   <= 1'b1;
                        conv_channel <= nxt_ch;
                        conv_avg     <= run_int;
                        ch_reg       <= nxt_ch;
                        first_reg    <= 1'b0;
                        cnt_reg      <= cnt_reg + 5'h01;
                        state_reg    <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (conv_done) begin
                        res_reg   <= {ch_reg, conv_data};
                        state_reg <= ST_HAND;
                    end
                end
                ST_HAND: begin
                    // Internal results go to the FIFO, others wait for the buffer
                    if (run_int || buf_in.ready) state_reg <= ST_ISSUE;
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // ========================================
    // Result FIFO for internally paced modes
    assign fifo_push = (state_reg == ST_HAND) && run_int;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fifo_wp_reg  <= 4'h0;
            fifo_rp_reg  <= 4'h0;
            fifo_cnt_reg <= 5'h00;
        end else if (start_req && state_reg == ST_IDLE) begin
            fifo_wp_reg  <= 4'h0;
            fifo_rp_reg  <= 4'h0;
            fifo_cnt_reg <= 5'h00;
        end else begin
            if (fifo_push) fifo_wp_reg <= fifo_wp_reg + 4'h1;
            if (fifo_pop)  fifo_rp_reg <= fifo_rp_reg + 4'h1;
            fifo_cnt_reg <= fifo_cnt_reg + 5'(fifo_push) - 5'(fifo_pop);
        end
    end

    always_ff @(posedge hclk) begin
        if (fifo_push) fifo_mem[fifo_wp_reg] <= res_reg;
    end

    // ========================================
    // Stream out through the two-entry buffer
    assign buf_in.valid  = (state_reg == ST_HAND) && !run_int;
    assign buf_in.data   = res_reg;
    assign buf_out.ready = res_ready;
    assign res_valid     = buf_out.valid;
    assign res_data      = buf_out.data;

    asq_pair_buf u_buf (
        .hclk    (hclk),
        .hresetn (hresetn),
        .in_s    (buf_in),
        .out_s   (buf_out)
    );

    // ========================================
    // Checks
    logic [3:0] last_ch_q;
    logic       had_conv_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            last_ch_q  <= 4'h0;
            had_conv_q <= 1'b0;
        end else begin
            if (start_req && state_reg == ST_IDLE) had_conv_q <= 1'b0;
            else if (conv_start) had_conv_q <= 1'b1;
            if (conv_start) last_ch_q <= conv_channel;
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_std_range: assert property (conv_start && run_std |-> conv_channel <= run_pick_reg)
        else $error("standard scan past boundary");
    a_std_first: assert property (conv_start && run_std && !had_conv_q |-> conv_channel == 4'h0)
        else $error("standard scan did not start at input 0");
    a_upper_first: assert property (conv_start && !run_custom && !run_std && !had_conv_q
        |-> conv_channel == run_pick_reg) else $error("upper scan did not start at N");
    a_ascend_order: assert property (conv_start && had_conv_q |-> conv_channel > last_ch_q)
        else $error("channel order not ascending");
    a_avg_by_mode: assert property (conv_start |-> conv_avg == run_int)
        else $error("averaging flag wrong for mode");
    a_ext_paced: assert property (conv_start && !run_int |-> $past(ext_tick))
        else $error("external mode converted without frame tick");
    a_list_member: assert property (conv_start && run_custom |-> list_all[conv_channel])
        else $error("custom scan left the channel list");
    a_conv_limit: assert property (cnt_reg <= MAX_CONV)
        else $error("more than sixteen conversions");
    a_unused_hold: assert property (wr_pend_reg && wr_addr_reg == OFS_MODE
        && !(wr_scan >= SCAN_STD_EXT && wr_scan <= SCAN_CUS_EXT)
        |=> $stable(mode_reg) && $stable(channel_pick_field)) else $error("unused code changed mode");
    a_fifo_fill: assert property (fifo_push && !fifo_pop |=> fifo_cnt_reg == $past(fifo_cnt_reg) + 5'h01)
        else $error("FIFO count did not grow");

    c_std_seq:  cover property (conv_start && run_std ##[1:200] state_reg == ST_IDLE);
    c_cus_int:  cover property (fifo_push && run_custom);
    c_up_ext:   cover property (res_valid && !res_ready && run_mode_reg == SCAN_UP_EXT);
    c_unused:   cover property (wr_pend_reg && wr_addr_reg == OFS_MODE && wr_scan == 4'h0);
endmodule

/* sim/asq_conv_model.sv */
// Converter and serial-frame model on the far side of the sequencer.
// Assumes the one clock and a one-pulse start, one-pulse done handshake.
`timescale 1ns/1ps
module asq_conv_model
    import asq_pkg::*;
(
    input  wire logic         hclk,
    input  wire logic         hresetn,
    input  wire logic         conv_start,
    input  wire logic [3:0]   conv_channel,
    output logic              conv_done,
    output logic [DATA_W-1:0] conv_data,
    output logic              ext_tick
);
    logic [1:0] wait_cnt;
    logic [2:0] frame_cnt;
    // ========================================
    // Conversion: done four cycles after start
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wait_cnt  <= 2'h0;
            conv_done <= 1'b0;
            conv_data <= 12'h000;
        end else begin
            wait_cnt  <= conv_start ? 2'h3 : (wait_cnt != 2'h0 ? wait_cnt - 2'h1 : 2'h0);
            conv_done <= (wait_cnt == 2'h1);
            // Word tied to channel; outside done it toggles every cycle
            conv_data <= (wait_cnt == 2'h1) ? {8'hC0, conv_channel} : ~conv_data;
        end
    end
    // ========================================
    // Serial frame pulse every eight cycles
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            frame_cnt <= 3'h0;
            ext_tick  <= 1'b0;
        end else begin
            frame_cnt <= frame_cnt + 3'h1;
            ext_tick  <= (frame_cnt == 3'h7);
        end
    end
endmodule

/* sim/tb_adc_scan_mode_sequencer.sv */
// Self-checking bench: AHB-Lite register tasks, scan runs per mode.
// Assumes the converter model and a receiver that stalls for long spans.
`timescale 1ns/1ps
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin errors++; \
    $display("Error at %0t: got %h expected %h", $time, got, exp); end end
module tb_adc_scan_mode_sequencer;
    import asq_pkg::*;
    logic hclk = 1'b0;
    logic res_ready = 1'b0;
    logic hresetn, hsel, hwrite, hreadyout, hresp, ext_tick, conv_done;
    logic conv_start, conv_avg, res_valid;
    logic [7:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata, r;
    logic [DATA_W-1:0] conv_data;
    logic [3:0] conv_channel;
    logic [RES_W-1:0] res_data;
    logic [5:0] tcnt = 6'h0;
    logic [3:0] chq[$];
    logic [RES_W-1:0] resq[$];
    int errors, samples_checked;
    asq_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .ext_tick(ext_tick), .conv_done(conv_done),
        .conv_data(conv_data), .conv_start(conv_start), .conv_channel(conv_channel),
        .conv_avg(conv_avg), .res_valid(res_valid), .res_data(res_data), .res_ready(res_ready));
    asq_conv_model conv (.hclk(hclk), .hresetn(hresetn), .conv_start(conv_start),
        .conv_channel(conv_channel), .conv_done(conv_done), .conv_data(conv_data), .ext_tick(ext_tick));
    // ========================================
    // Clock, receiver stalling 48 of 64 cycles, start and result log
    always #50 hclk = ~hclk;
    always @(posedge hclk) begin
        tcnt <= tcnt + 6'h1;
        res_ready <= (tcnt[5:4] == 2'b11);
        if (conv_start === 1'b1) chq.push_back(conv_channel);
        if (res_valid === 1'b1 && res_ready === 1'b1) resq.push_back(res_data);
    end
    // ========================================
    // One single transfer: address phase, then data phase
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    // ========================================
    // One scan: start, wait idle, compare channels, stream or FIFO
    task automatic run(input logic [3:0] code, input logic [3:0] pick, input logic [15:0] emask,
                       input logic ext);
        int k;
        logic [3:0] fc;
        fc = 4'h0;
        chq.delete();
        resq.delete();
        bus(OFS_MODE, 1'b1, (32'(code) << MODE_SCAN_LSB) | (32'(pick) << MODE_CHSEL_LSB));
        bus(OFS_CMD, 1'b1, 32'h1);
        r = 32'h1;
        while (r[0] !== 1'b0) bus(OFS_STATUS, 1'b0, 32'h0);
        repeat (70) @(posedge hclk);
        k = 0;
        for (int c = 0; c < NCH; c++) begin
            if (emask[c]) begin
                if (k == 0) fc = 4'(c);
                `CHK(chq[k], 4'(c))
                if (ext) `CHK(resq[k], {4'(c), 8'hC0, 4'(c)})
                k++;
            end
        end
        `CHK(32'(chq.size()), 32'(k))
        `CHK(32'(resq.size()), (ext ? 32'(k) : 32'h0))
        `CHK(conv_avg, ~ext)
        if (!ext) begin
            bus(OFS_STATUS, 1'b0, 32'h0);
            `CHK(r[12:8], 5'(k))
            bus(OFS_RESULT, 1'b0, 32'h0);
            `CHK(r, {15'h0, 1'b1, fc, 8'hC0, fc})
        end
    endtask
    // ========================================
    // Verdict and end of run
    task automatic report_and_stop;
        $display("Checks %0d, mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // ========================================
    // Watchdog, far beyond the expected few thousand cycles
    initial begin
        #5000000;
        errors++;
        report_and_stop();
    end
    // ========================================
    // Main sequence
    initial begin
        hresetn = 1'b0; hsel = 1'b0; haddr = 8'h00; htrans = 2'b00;
        hwrite = 1'b0; hsize = 3'h2; hwdata = 32'h0;
        errors = 0; samples_checked = 0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        bus(OFS_MODE, 1'b0, 32'h0);
        `CHK(r, 32'h0000_2000)
        bus(OFS_CFG, 1'b0, 32'h0);
        `CHK(r, 32'h0000_0002)
        bus(8'h1C, 1'b0, 32'h0);
        `CHK(r, 32'h0)
        `CHK(hresp, 1'b0)
        `CHK(hreadyout, 1'b1)
        // Unused codes leave mode and pick untouched
        bus(OFS_MODE, 1'b1, 32'h0000_52FF);
        bus(OFS_MODE, 1'b1, 32'h0000_07FF);
        bus(OFS_MODE, 1'b0, 32'h0);
        `CHK(r, 32'h0000_2000)
        run(SCAN_STD_EXT, 4'h2, 16'h0007, 1'b1);
        run(SCAN_UP_EXT, 4'hD, 16'hE000, 1'b1);
        run(SCAN_UP_EXT, 4'hF, 16'h8000, 1'b1);
        // Eight-channel variant, boundary inside it
        bus(OFS_CFG, 1'b1, 32'h1);
        run(SCAN_UP_INT, 4'h5, 16'h00E0, 1'b0);
        // Four-channel variant: FIFO holds four minus N results
        bus(OFS_CFG, 1'b1, 32'h0);
        run(SCAN_UP_INT, 4'h1, 16'h000E, 1'b0);
        bus(OFS_CFG, 1'b1, 32'h2);
        // Sparse list; pick field must be ignored
        bus(OFS_LIST_LO, 1'b1, 32'h05);
        bus(OFS_LIST_HI, 1'b1, 32'h80);
        run(SCAN_CUS_EXT, 4'h9, 16'h8005, 1'b1);
        // Full list: sixteen averaged conversions into the FIFO
        bus(OFS_LIST_LO, 1'b1, 32'hFF);
        bus(OFS_LIST_HI, 1'b1, 32'hFF);
        run(SCAN_CUS_INT, 4'h0, 16'hFFFF, 1'b0);
        report_and_stop();
    end
endmodule
